// >>> vps_pkg.sv
// Purpose: Shared constants and types for the video port sync link
// Assumes: Link timing is counted in link clock cycles
// Notes: Pixel timing unit is a whole number of link clock cycles
package vps_pkg;
  // Pulse mode sync widths and first pixel offset, in pixel timing units
  localparam int SYNC_UNITS = 3;
  localparam int FIRST_PIX_RAW = 145;
  localparam int FIRST_PIX_UNITS = FIRST_PIX_RAW - 1;
  // Slave mode trigger limits, in link clock cycles
  localparam int ROW_TRIG_MIN = 2;
  localparam int FRAME_TRIG_MIN = 3;
  localparam int FRAME_TAIL_MIN = 1;
  localparam int FRAME_TAIL_MAX = 96;
  // Cycles spent in the trigger synchroniser and output registers
  localparam int SLAVE_PIPE = 4;
  // Defaults
  localparam int PIX_W_DEF = 10;
  localparam int ACT_COLS_DEF = 648;
  localparam int ROWS_DEF = 488;
  localparam int ROW_LEN_DEF = 824;
  localparam int FRAME_LEN_DEF = ROW_LEN_DEF * ROWS_DEF;
  localparam int UNIT_DIV_DEF = 2;
  localparam int LAT_DEF = 16;
  localparam int LINK_DIV_DEF = 4;
  localparam int FRAME_TAIL_DEF = 8;
  localparam int ROW_GAP_DEF = 8;
  localparam int ROW_IDX_W = 16;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;

  typedef enum logic [1:0] {
    VPS_H_IDLE = 2'b00,
    VPS_H_LEAD = 2'b01,
    VPS_H_ROW = 2'b10,
    VPS_H_TAIL = 2'b11
  } vps_hstate_t;
endpackage

// >>> vps_if.sv
// Purpose: Pins between the video port device and its host
// Assumes: Sync pins are two-way and pulled low when nobody drives
// Notes: Host drives the link clock; device drives pixel pins
`timescale 1ns/1ps
interface vps_if #(
  parameter int PIX_W = 10
);
  logic link_clk;
  logic dev_ls_o;
  logic dev_ls_oe;
  logic dev_fs_o;
  logic dev_fs_oe;
  logic host_ls_o;
  logic host_ls_oe;
  logic host_fs_o;
  logic host_fs_oe;
  logic pclk;
  logic pix_valid;
  logic [PIX_W-1:0] pix_data;
  wire ls;
  wire fs;

  // Resolved level of the two-way sync wires
  assign ls = dev_ls_oe ? dev_ls_o : (host_ls_oe ? host_ls_o : 1'b0);
  assign fs = dev_fs_oe ? dev_fs_o : (host_fs_oe ? host_fs_o : 1'b0);

  modport dev (
    input link_clk, ls, fs,
    output dev_ls_o, dev_ls_oe, dev_fs_o, dev_fs_oe,
    output pclk, pix_valid, pix_data
  );
  modport host (
    output link_clk, host_ls_o, host_ls_oe, host_fs_o, host_fs_oe,
    input ls, fs, pclk, pix_valid, pix_data
  );
endinterface

// >>> vps_dev.sv
// Purpose: Image sensor video port: pulse mode master or triggered slave
// Assumes: Runs on the link clock; i_rst is synchronous to it
// Notes: pclk toggles once per pixel; in pulse mode it also toggles through blanking
`timescale 1ns/1ps
module vps_dev
  import vps_pkg::*;
#(
  parameter int PIX_W = PIX_W_DEF,
  parameter int ACT_COLS = ACT_COLS_DEF,
  parameter int ROW_LEN = ROW_LEN_DEF,
  parameter int FRAME_LEN = FRAME_LEN_DEF,
  parameter int UNIT_DIV = UNIT_DIV_DEF,
  parameter int LAT = LAT_DEF
) (
  // Link pins
  vps_if.dev link,
  // Control
  input wire logic i_rst,
  input wire logic i_slave_mode,
  // Status
  output logic [ROW_IDX_W-1:0] o_row_index,
  output logic o_frame_pulse
);
  localparam int CW = $clog2(FRAME_LEN + 1);

  function automatic logic [PIX_W-1:0] pix_pattern(
    input logic [ROW_IDX_W-1:0] row,
    input logic [CW-1:0] col
  );
    logic [CW+ROW_IDX_W-1:0] mix;
    mix = {row, col} ^ {{CW{1'b0}}, row};
    pix_pattern = mix[PIX_W-1:0];
  endfunction

  // Master counters
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [CW-1:0] col_reg;
  logic [CW-1:0] col_next;
  logic [CW-1:0] frm_reg;
  logic [CW-1:0] frm_next;
  logic tick_d_reg;
  // Slave trigger path
  logic [2:0] row_sync_reg;
  logic [2:0] frm_sync_reg;
  logic wait_reg;
  logic wait_next;
  logic [CW-1:0] wcnt_reg;
  logic [CW-1:0] wcnt_next;
  logic emit_reg;
  logic emit_next;
  logic [CW-1:0] ecol_reg;
  logic [CW-1:0] ecol_next;
  // Outputs
  logic ls_reg;
  logic fs_reg;
  logic oe_reg;
  logic valid_reg;
  logic [PIX_W-1:0] data_reg;
  logic [PIX_W-1:0] data_next;
  logic pclk_reg;
  logic [ROW_IDX_W-1:0] row_reg;
  logic [ROW_IDX_W-1:0] row_next;
  logic frame_pulse_reg;

  // Master pulse mode timing
  wire unit_tick = div_reg == DIV_W'(UNIT_DIV - 1);
  wire col_wrap = col_reg == CW'(ROW_LEN - 1);
  wire frm_wrap = frm_reg == CW'(FRAME_LEN - 1);
  assign div_next = unit_tick ? DIV_ZERO : div_reg + 1'b1;
  assign col_next = !unit_tick ? col_reg :
                    col_wrap ? '0 : col_reg + 1'b1;
  assign frm_next = !unit_tick ? frm_reg :
                    frm_wrap ? '0 : frm_reg + 1'b1;
  wire m_ls = col_reg < CW'(SYNC_UNITS);
  wire m_fs = frm_reg < CW'(SYNC_UNITS);
  wire m_valid = (col_reg >= CW'(FIRST_PIX_UNITS)) &&
                 (col_reg < CW'(FIRST_PIX_UNITS + ACT_COLS));
  wire [CW-1:0] m_col = col_reg - CW'(FIRST_PIX_UNITS);
  wire m_row_end = unit_tick && col_wrap;
  wire m_frame_end = unit_tick && frm_wrap;

  // Slave trigger edges after the two-stage synchroniser
  wire row_fall = row_sync_reg[2] && !row_sync_reg[1];
  wire frm_rise = frm_sync_reg[1] && !frm_sync_reg[2];
  wire wcnt_done = wcnt_reg == '0;
  wire ecol_last = ecol_reg == CW'(ACT_COLS - 1);

  // Fixed readout latency, counted from the synchronised fall
  always_comb begin
    wait_next = wait_reg;
    wcnt_next = wcnt_reg;
    emit_next = emit_reg;
    ecol_next = ecol_reg;
    if (row_fall) begin
      wait_next = 1'b1;
      wcnt_next = CW'(LAT - SLAVE_PIPE);
    end else if (wait_reg) begin
      if (wcnt_done) begin
        wait_next = 1'b0;
        emit_next = 1'b1;
        ecol_next = '0;
      end else begin
        wcnt_next = wcnt_reg - 1'b1;
      end
    end
    if (emit_reg && !(wait_reg && wcnt_done)) begin
      ecol_next = ecol_reg + 1'b1;
      if (ecol_last) begin
        emit_next = 1'b0;
      end
    end
  end

  // Row index and output selection per mode
  wire s_row_end = emit_reg && ecol_last;
  always_comb begin
    row_next = row_reg;
    if (i_slave_mode) begin
      if (frm_rise) begin
        row_next = '0;
      end else if (s_row_end) begin
        row_next = row_reg + 1'b1;
      end
    end else begin
      if (m_frame_end) begin
        row_next = '0;
      end else if (m_row_end) begin
        row_next = row_reg + 1'b1;
      end
    end
  end
  assign data_next = i_slave_mode ? pix_pattern(row_reg, ecol_reg) :
                     pix_pattern(row_reg, m_col);
  wire pix_step = i_slave_mode ? emit_reg : tick_d_reg;
  wire valid_sel = i_slave_mode ? emit_reg : m_valid;
  wire frame_evt = i_slave_mode ? frm_rise : m_frame_end;

  always_ff @(posedge link.link_clk) begin
    if (i_rst || i_slave_mode) begin
      div_reg <= DIV_ZERO;
      col_reg <= '0;
      frm_reg <= '0;
      tick_d_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      col_reg <= col_next;
      frm_reg <= frm_next;
      tick_d_reg <= unit_tick;
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (i_rst) begin
      row_sync_reg <= 3'h0;
      frm_sync_reg <= 3'h0;
    end else begin
      row_sync_reg <= {row_sync_reg[1:0], link.ls};
      frm_sync_reg <= {frm_sync_reg[1:0], link.fs};
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (i_rst || !i_slave_mode) begin
      wait_reg <= 1'b0;
      wcnt_reg <= '0;
      emit_reg <= 1'b0;
      ecol_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      wcnt_reg <= wcnt_next;
      emit_reg <= emit_next;
      ecol_reg <= ecol_next;
    end
  end

  // Registered pins, all timed from the link clock
  always_ff @(posedge link.link_clk) begin
    if (i_rst) begin
      ls_reg <= 1'b0;
      fs_reg <= 1'b0;
      oe_reg <= 1'b0;
      valid_reg <= 1'b0;
      data_reg <= '0;
      pclk_reg <= 1'b0;
      row_reg <= '0;
      frame_pulse_reg <= 1'b0;
    end else begin
      ls_reg <= !i_slave_mode && m_ls;
      fs_reg <= !i_slave_mode && m_fs;
      oe_reg <= !i_slave_mode;
      valid_reg <= valid_sel;
      data_reg <= data_next;
      if (pix_step) begin
        pclk_reg <= !pclk_reg;
      end
      row_reg <= row_next;
      frame_pulse_reg <= frame_evt;
    end
  end

  assign link.dev_ls_o = ls_reg;
  assign link.dev_ls_oe = oe_reg;
  assign link.dev_fs_o = fs_reg;
  assign link.dev_fs_oe = oe_reg;
  assign link.pclk = pclk_reg;
  assign link.pix_valid = valid_reg;
  assign link.pix_data = data_reg;
  assign o_row_index = row_reg;
  assign o_frame_pulse = frame_pulse_reg;
endmodule

// >>> vps_host.sv
// Purpose: Capture controller: makes the link clock, paces slave readout
// Assumes: i_mclk domain; link clock is i_mclk divided by LINK_DIV
// Notes: Pixel pins pass three flip-flops before use; LINK_DIV >= 4
`timescale 1ns/1ps
module vps_host
  import vps_pkg::*;
#(
  parameter int PIX_W = PIX_W_DEF,
  parameter int LINK_DIV = LINK_DIV_DEF,
  parameter int ROWS = ROWS_DEF,
  parameter int ROW_PERIOD = LAT_DEF + ACT_COLS_DEF + ROW_GAP_DEF,
  parameter int FRAME_TAIL = FRAME_TAIL_DEF
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Link pins
  vps_if.host link,
  // Control
  input wire logic i_slave_mode,
  input wire logic i_frame_go,
  // Captured stream
  output logic [PIX_W-1:0] o_pix_data,
  output logic o_pix_valid,
  output logic o_line_start,
  output logic o_frame_start,
  output logic o_busy
);
  localparam int PW = $clog2(ROW_PERIOD + 1);
  localparam int RW = $clog2(ROWS + 1);

  vps_hstate_t st_reg;
  vps_hstate_t st_next;
  logic [DIV_W-1:0] lk_reg;
  logic lclk_reg;
  logic [PW-1:0] pc_reg;
  logic [PW-1:0] pc_next;
  logic [RW-1:0] rc_reg;
  logic [RW-1:0] rc_next;
  logic go_reg;
  logic ls_reg;
  logic fs_reg;
  logic oe_reg;
  logic [3:0] pclk_s_reg;
  logic [2:0] val_s_reg;
  logic [2:0] ls_s_reg;
  logic [2:0] fs_s_reg;
  logic [PIX_W-1:0] d1_reg;
  logic [PIX_W-1:0] d2_reg;
  logic [PIX_W-1:0] d3_reg;
  logic [PIX_W-1:0] pix_reg;
  logic pv_reg;
  logic lst_reg;
  logic fst_reg;

  // Link clock divider; tick marks the edge that raises it
  wire tick = lk_reg == DIV_W'(LINK_DIV - 1);
  wire [DIV_W-1:0] lk_next = tick ? DIV_ZERO : lk_reg + 1'b1;
  wire lclk_next = lk_next < DIV_W'(LINK_DIV / 2);
  // Triggers change as the link clock falls, half a period from sampling
  wire fall_tick = lk_reg == DIV_W'(LINK_DIV / 2 - 1);

  // Slave pacing, counted in link clock cycles
  wire lead_done = pc_reg == PW'(FRAME_TRIG_MIN - 1);
  wire trig_end = pc_reg == PW'(ROW_TRIG_MIN - 1);
  wire per_end = pc_reg == PW'(ROW_PERIOD - 1);
  wire last_row = rc_reg == RW'(ROWS - 1);
  always_comb begin
    st_next = st_reg;
    pc_next = pc_reg + 1'b1;
    rc_next = rc_reg;
    unique case (st_reg)
      VPS_H_IDLE: begin
        pc_next = '0;
        rc_next = '0;
        if (go_reg && i_slave_mode) begin
          st_next = VPS_H_LEAD;
        end
      end
      VPS_H_LEAD: begin
        if (lead_done) begin
          st_next = VPS_H_ROW;
          pc_next = '0;
        end
      end
      VPS_H_ROW: begin
        if (last_row && trig_end) begin
          st_next = VPS_H_TAIL;
          pc_next = '0;
        end else if (per_end) begin
          rc_next = rc_reg + 1'b1;
          pc_next = '0;
        end
      end
      VPS_H_TAIL: begin
        // Next frame waits until the last row has been read out
        if (per_end) begin
          st_next = VPS_H_IDLE;
        end
      end
    endcase
  end
  wire ls_next = (st_next == VPS_H_ROW) &&
                 (pc_next < PW'(ROW_TRIG_MIN));
  wire fs_drop = (st_next == VPS_H_TAIL) &&
                 (pc_next >= PW'(FRAME_TAIL));
  wire fs_next = (st_next != VPS_H_IDLE) && !fs_drop;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lk_reg <= DIV_ZERO;
      lclk_reg <= 1'b0;
      st_reg <= VPS_H_IDLE;
      pc_reg <= '0;
      rc_reg <= '0;
      go_reg <= 1'b0;
      ls_reg <= 1'b0;
      fs_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      lk_reg <= lk_next;
      lclk_reg <= lclk_next;
      oe_reg <= i_slave_mode;
      if (i_frame_go) begin
        go_reg <= 1'b1;
      end else if (fall_tick && st_reg == VPS_H_IDLE) begin
        go_reg <= 1'b0;
      end
      if (fall_tick) begin
        st_reg <= st_next;
        pc_reg <= pc_next;
        rc_reg <= rc_next;
        ls_reg <= ls_next;
        fs_reg <= fs_next;
      end
    end
  end

  // Capture: sync all pins, take data from the stage in step with the detected pclk edge
  wire pclk_edge = pclk_s_reg[2] ^ pclk_s_reg[3];
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pclk_s_reg <= 4'h0;
      val_s_reg <= 3'h0;
      ls_s_reg <= 3'h0;
      fs_s_reg <= 3'h0;
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      pix_reg <= '0;
      pv_reg <= 1'b0;
      lst_reg <= 1'b0;
      fst_reg <= 1'b0;
    end else begin
      pclk_s_reg <= {pclk_s_reg[2:0], link.pclk};
      val_s_reg <= {val_s_reg[1:0], link.pix_valid};
      ls_s_reg <= {ls_s_reg[1:0], link.ls};
      fs_s_reg <= {fs_s_reg[1:0], link.fs};
      d1_reg <= link.pix_data;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
      pv_reg <= pclk_edge && val_s_reg[2];
      if (pclk_edge) begin
        pix_reg <= d3_reg;
      end
      lst_reg <= ls_s_reg[1] && !ls_s_reg[2];
      fst_reg <= fs_s_reg[1] && !fs_s_reg[2];
    end
  end

  assign link.link_clk = lclk_reg;
  assign link.host_ls_o = ls_reg;
  assign link.host_ls_oe = oe_reg;
  assign link.host_fs_o = fs_reg;
  assign link.host_fs_oe = oe_reg;
  assign o_pix_data = pix_reg;
  assign o_pix_valid = pv_reg;
  assign o_line_start = lst_reg;
  assign o_frame_start = fst_reg;
  assign o_busy = fs_reg;
endmodule

// >>> vps_link_assertions.sv
// Purpose: Timing checks on the wires between the two video port ends
// Assumes: Everything is sampled on rising link clock edges
// Notes: Ages count link cycles since a sync edge and rest at zero
`timescale 1ns/1ps
module vps_link_assertions
  import vps_pkg::*;
#(
  parameter int UNIT_DIV = UNIT_DIV_DEF,
  parameter int ROW_LEN = ROW_LEN_DEF,
  parameter int FRAME_LEN = FRAME_LEN_DEF,
  parameter int ACT_COLS = ACT_COLS_DEF,
  parameter int LAT = LAT_DEF
) (
  // Link clock and device reset
  input wire logic link_clk,
  input wire logic i_rst,
  // Mode
  input wire logic i_slave_mode,
  // Link wires
  input wire logic ls,
  input wire logic fs,
  input wire logic pclk,
  input wire logic pix_valid
);
  localparam int TRIG_WIN = 64;
  localparam int U3 = SYNC_UNITS * UNIT_DIV;
  logic ls_q_reg, fs_q_reg;
  logic [31:0] lsa_reg, fsa_reg, fla_reg;
  wire logic m = ~i_slave_mode;
  wire logic ls_rise = ls & ~ls_q_reg;
  wire logic ls_fall = ~ls & ls_q_reg;
  wire logic fs_rise = fs & ~fs_q_reg;
  // An age stays at zero until its first edge, so first runs are skipped
  wire logic [31:0] lsa_next = ls_rise ? 32'h1 : lsa_reg + 32'(lsa_reg != 0);
  wire logic [31:0] fsa_next = fs_rise ? 32'h1 : fsa_reg + 32'(fsa_reg != 0);
  wire logic [31:0] fla_next = ls_fall ? 32'h1 : fla_reg + 32'(fla_reg != 0);

  always_ff @(posedge link_clk) begin
    if (i_rst) begin
      {ls_q_reg, fs_q_reg, lsa_reg, fsa_reg, fla_reg} <= '0;
    end else begin
      {ls_q_reg, fs_q_reg} <= {ls, fs};
      {lsa_reg, fsa_reg, fla_reg} <= {lsa_next, fsa_next, fla_next};
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (i_rst);

  line_high_len_a: assert property (m && $fell(ls) |-> lsa_reg == U3)
    else $error("line sync high width wrong");
  line_period_a: assert property (m && $rose(ls) && lsa_reg != 0
    |-> lsa_reg == ROW_LEN * UNIT_DIV) else $error("row length wrong");
  frame_high_len_a: assert property (m && $fell(fs) |-> fsa_reg == U3)
    else $error("frame sync high width wrong");
  frame_period_a: assert property (m && $rose(fs) && fsa_reg != 0
    |-> fsa_reg == FRAME_LEN * UNIT_DIV) else $error("frame length wrong");
  first_pixel_a: assert property (m && $rose(pix_valid)
    |-> lsa_reg == FIRST_PIX_UNITS * UNIT_DIV)
    else $error("first pixel offset wrong");
  row_trig_w_a: assert property (!m && $fell(ls)
    |-> lsa_reg >= ROW_TRIG_MIN) else $error("row trigger too short");
  // Fall counts from the edge that samples it, rise one edge after launch
  slave_latency_a: assert property (!m && $rose(pix_valid)
    |-> fla_reg == LAT + 1) else $error("slave readout latency wrong");
  row_space_a: assert property (!m && $rose(ls) && lsa_reg != 0
    |-> lsa_reg >= LAT + ACT_COLS) else $error("row triggers too close");
  frame_tail_a: assert property (!m && $fell(fs)
    |-> fla_reg inside {[FRAME_TAIL_MIN:FRAME_TAIL_MAX]})
    else $error("frame trigger tail out of range");
  frame_trig_w_a: assert property (!m && $fell(fs)
    |-> fsa_reg >= FRAME_TRIG_MIN) else $error("frame trigger too short");
  trig_readout_a: assert property (!m && $fell(ls)
    |-> ##[1:TRIG_WIN] $rose(pix_valid)) else $error("trigger gave no row");
  pclk_toggle_a: assert property (!m && pix_valid && $past(pix_valid)
    |-> pclk != $past(pclk)) else $error("pixel clock did not toggle");

  cover property (m && $rose(fs) && fsa_reg != 0);
  cover property (!m && $rose(pix_valid));
  cover property (!m && $fell(fs));
endmodule

// >>> video_port_sync_timing_test.sv
// Purpose: Runs both link ends in pulse mode, then in slave mode
// Assumes: The host makes the link clock from i_mclk
// Notes: Row, pixel and frame counts are taken at the host's captured outputs
`timescale 1ns/1ps
module video_port_sync_timing_test;
  import vps_pkg::*;
  localparam int UD = 2;
  localparam int RL = 200;
  localparam int FL = 2000;
  localparam int AC = 40;
  localparam int LT = 16;
  localparam int LD = 4;
  localparam int NR = 4;
  logic i_mclk = 1'b0;
  logic h_rst = 1'b1;
  logic d_rst = 1'b1;
  logic slave = 1'b0;
  logic go = 1'b0;
  logic h_pv, h_ls, h_fs, h_busy, d_fp;
  logic [PIX_W_DEF-1:0] h_pd;
  logic [ROW_IDX_W-1:0] d_row;
  int prow = 0;
  int pcol = 0;
  bit pend = 1'b0;
  int failures = 0;
  int n_compared = 0;
  // Counts: mclk cycles, rows, pixels, frames, device frame pulses
  int cnt [5] = '{0, 0, 0, 0, 0};
  int snap_cnt [5];

  vps_if #(.PIX_W(PIX_W_DEF)) link ();
  vps_host #(.LINK_DIV(LD), .ROWS(NR), .ROW_PERIOD(LT + AC + 8),
    .FRAME_TAIL(8)) u_vps_host (.i_mclk(i_mclk), .i_rst(h_rst),
    .link(link.host), .i_slave_mode(slave), .i_frame_go(go),
    .o_pix_data(h_pd), .o_pix_valid(h_pv), .o_line_start(h_ls),
    .o_frame_start(h_fs), .o_busy(h_busy));
  vps_dev #(.ACT_COLS(AC), .ROW_LEN(RL), .FRAME_LEN(FL), .UNIT_DIV(UD),
    .LAT(LT)) u_vps_dev (.link(link.dev), .i_rst(d_rst),
    .i_slave_mode(slave), .o_row_index(d_row), .o_frame_pulse(d_fp));
  vps_link_assertions #(.UNIT_DIV(UD), .ROW_LEN(RL), .FRAME_LEN(FL),
    .ACT_COLS(AC), .LAT(LT)) u_vps_link_assertions (
    .link_clk(link.link_clk), .i_rst(d_rst), .i_slave_mode(slave),
    .ls(link.ls), .fs(link.fs), .pclk(link.pclk),
    .pix_valid(link.pix_valid));

  always #2.5 i_mclk = ~i_mclk;

  always @(posedge i_mclk) begin
    cnt[0]++;
    if (h_ls === 1'b1) cnt[1]++;
    if (h_pv === 1'b1) cnt[2]++;
    if (h_fs === 1'b1) cnt[3]++;
  end

  always @(posedge link.link_clk) begin
    if (d_fp === 1'b1) cnt[4]++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (exp !== got) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    n_compared++;
    if (exp !== got) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Captured pixel value follows row and column within the frame
  always @(posedge i_mclk) begin
    if (h_fs === 1'b1) begin
      prow = 0;
      pcol = 0;
      pend = (h_ls !== 1'b1);
    end else if (h_ls === 1'b1) begin
      prow = pend ? prow : prow + 1;
      pcol = 0;
      pend = 1'b0;
    end
    if (h_pv === 1'b1) begin
      chk("pixel data", (pcol ^ prow) % (1 << PIX_W_DEF), h_pd);
      pcol++;
    end
  end

  task automatic test_done();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Device reset spans link edges, so the host keeps the link clock going
  task automatic start(input logic mode);
    @(posedge i_mclk);
    #1 d_rst = 1'b1;
    if (h_rst !== 1'b1) begin
      repeat (24) @(posedge i_mclk);
      #1;
    end
    h_rst = 1'b1;
    slave = mode;
    repeat (4) @(posedge i_mclk);
    #1 h_rst = 1'b0;
    repeat (24) @(posedge i_mclk);
    #1 d_rst = 1'b0;
  endtask

  task automatic pulse_go();
    @(posedge i_mclk);
    #1 go = 1'b1;
    @(posedge i_mclk);
    #1 go = 1'b0;
  endtask

  task automatic wait_cnt(input int i, input int n);
    int t;
    t = 0;
    do begin
      @(posedge i_mclk);
      #1;
      t++;
    end while (cnt[i] - snap_cnt[i] < n && t < 40000);
  endtask

  initial begin
    int t;
    start(1'b0);
    pulse_go();
    repeat (8) @(posedge i_mclk);
    #1;
    chk_bit("busy in pulse mode", 1'b0, h_busy);
    snap_cnt = cnt;
    wait_cnt(3, 1);
    snap_cnt = cnt;
    wait_cnt(3, 1);
    chk("frame mclk cycles", FL * UD * LD, cnt[0] - snap_cnt[0]);
    chk("rows per frame", FL / RL, cnt[1] - snap_cnt[1]);
    chk("pixels per frame", FL / RL * AC, cnt[2] - snap_cnt[2]);
    chk("device frame pulses", 1, cnt[4] - snap_cnt[4]);
    snap_cnt = cnt;
    wait_cnt(1, 1);
    chk("row mclk cycles", RL * UD * LD, cnt[0] - snap_cnt[0]);
    start(1'b1);
    snap_cnt = cnt;
    // Second request lands while the first frame is under way
    pulse_go();
    t = 0;
    while (h_busy !== 1'b1 && t < 400) begin
      @(posedge i_mclk);
      #1;
      t++;
    end
    pulse_go();
    wait_cnt(3, 2);
    t = 0;
    while (h_busy !== 1'b0 && t < 4000) begin
      @(posedge i_mclk);
      #1;
      t++;
    end
    // Let the last row drain through capture
    repeat ((LT + AC) * LD * 2) @(posedge i_mclk);
    chk("slave frames", 2, cnt[3] - snap_cnt[3]);
    chk("slave device frame pulses", 2, cnt[4] - snap_cnt[4]);
    chk("slave rows", 2 * NR, cnt[1] - snap_cnt[1]);
    chk("slave pixels", 2 * NR * AC, cnt[2] - snap_cnt[2]);
    chk_bit("busy after frames", 1'b0, h_busy);
    chk("device row index", NR, d_row);
    test_done();
  end

  initial begin
    repeat (90000) @(posedge i_mclk);
    failures++;
    test_done();
  end
endmodule
